// file: rtl/alu_logic_regs.svh
// Summary of operation
// - single-word and: low 16 accumulator bits and memory word, result to accumulator
// - wide constant and acts on all 32 accumulator bits, result to accumulator
// - wide constant and takes an immediate of up to eight hex digits
// - every logic operation sets zero flag when result is zero, clears otherwise
// - wide, bit-range and stack and set negative flag from result msb
// - flags hold until the next instruction writing the same flags overwrites them
// - bit-range and gathers 1 to 32 consecutive discrete bits and ands them in
// - bit-range count is a constant between 1 and 32
// - stack and combines full accumulator with top stack entry into accumulator
// - stack and discards top entry and moves remaining entries up one level
// - single-word or: low 16 accumulator bits or memory word, result to accumulator
// - single-word or updates only the zero flag, never the negative flag
`ifndef ALU_LOGIC_REGS_SVH
`define ALU_LOGIC_REGS_SVH
`define ALU_DATA_W 32
`define ALU_HALF_W 16
`define ALU_MSB 31
`define ALU_STACK_DEPTH 8
`define ALU_BITMEM_N 1024
`define ALU_BITADDR_W 10
`define ALU_CNT_W 6
`define ALU_CNT_MIN 6'h01
`define ALU_CNT_MAX 6'h20
`define ALU_ACC_RESET 32'h0000_0000
`define ALU_HALF_ZERO 16'h0000
`endif

// file: rtl/alu_logic_pkg.sv
`include "alu_logic_regs.svh"
package alu_logic_pkg;
  typedef enum logic [5:0] {
    OP_LOAD = 6'h01,
    OP_AND_WORD = 6'h02,
    OP_AND_WIDE_CONST = 6'h04,
    OP_AND_BIT_RANGE = 6'h08,
    OP_AND_STACK = 6'h10,
    OP_OR_WORD = 6'h20
  } op_t;
  typedef struct packed {
    op_t op;
    logic enable;
    logic [`ALU_HALF_W-1:0] memWord;
    logic [`ALU_DATA_W-1:0] constWord;
    logic [`ALU_BITADDR_W-1:0] bitStart;
    logic [`ALU_CNT_W-1:0] bitCount;
  } cmd_t;
endpackage

// file: rtl/bit_gather.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_logic_regs.svh"
module bit_gather #(
  parameter int N = `ALU_BITMEM_N,
  parameter int AW = `ALU_BITADDR_W
) (
  input wire logic [N-1:0] bitMem,
  input wire logic [AW-1:0] start,
  input wire logic [`ALU_CNT_W-1:0] count,
  output logic [`ALU_DATA_W-1:0] pattern
);
  genvar i;
  generate
    for (i = 0; i < `ALU_DATA_W; i++) begin : g_bit
      wire logic [AW:0] idx;
      wire logic inRun;
      assign idx = {1'b0, start} + (AW+1)'(i);
      // bits past the end of memory read as zero rather than wrapping
      assign inRun = ((`ALU_CNT_W)'(i) < count) && (idx < (AW+1)'(N));
      assign pattern[i] = inRun ? bitMem[idx[AW-1:0]] : 1'b0;
    end
  endgenerate
endmodule
`default_nettype wire

// file: rtl/accumulator_logic_and_or_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_logic_regs.svh"
module accumulator_logic_and_or_unit #(
  parameter int STACK_DEPTH = `ALU_STACK_DEPTH,
  parameter int BITMEM_N = `ALU_BITMEM_N
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cmdValid,
  input wire alu_logic_pkg::cmd_t cmd,
  input wire logic [BITMEM_N-1:0] bitMem,
  output logic [`ALU_DATA_W-1:0] acc,
  output logic [`ALU_DATA_W-1:0] stackTop,
  output logic zero_result_flag,
  output logic negative_result_flag,
  output logic done,
  output logic badCount
);
  logic [`ALU_DATA_W-1:0] acc_q;
  logic [`ALU_DATA_W-1:0] acc_d;
  logic [`ALU_DATA_W-1:0] stack_q [STACK_DEPTH];
  logic zero_q;
  logic zero_d;
  logic neg_q;
  logic neg_d;
  logic done_q;
  logic badCount_q;

  wire alu_logic_pkg::op_t op;
  wire logic [`ALU_HALF_W-1:0] memWord;
  wire logic [`ALU_DATA_W-1:0] constWord;
  wire logic [`ALU_CNT_W-1:0] bitCount;
  wire logic [`ALU_DATA_W-1:0] pattern;
  assign op = cmd.op;
  assign memWord = cmd.memWord;
  assign constWord = cmd.constWord;
  assign bitCount = cmd.bitCount;

  bit_gather #(
    .N(BITMEM_N),
    .AW(`ALU_BITADDR_W)
  ) u_gather (
    .bitMem(bitMem),
    .start(cmd.bitStart),
    .count(bitCount),
    .pattern(pattern)
  );

  // a false enabling condition turns the instruction into a no-op
  wire logic take;
  assign take = cmdValid && cmd.enable;

  wire logic isLoad;
  wire logic isAndWord;
  wire logic isAndWide;
  wire logic isAndRange;
  wire logic isAndStack;
  wire logic isOrWord;
  assign isLoad = take && (op == alu_logic_pkg::OP_LOAD);
  assign isAndWord = take && (op == alu_logic_pkg::OP_AND_WORD);
  assign isAndWide = take && (op == alu_logic_pkg::OP_AND_WIDE_CONST);
  assign isAndRange = take && (op == alu_logic_pkg::OP_AND_BIT_RANGE);
  assign isAndStack = take && (op == alu_logic_pkg::OP_AND_STACK);
  assign isOrWord = take && (op == alu_logic_pkg::OP_OR_WORD);

  // count outside 1..32 is refused whole, nothing is touched
  wire logic countOk;
  wire logic rangeRun;
  wire logic rangeBad;
  assign countOk = (bitCount >= `ALU_CNT_MIN) && (bitCount <= `ALU_CNT_MAX);
  assign rangeRun = isAndRange && countOk;
  assign rangeBad = isAndRange && !countOk;

  wire logic [`ALU_DATA_W-1:0] andWordRes;
  wire logic [`ALU_DATA_W-1:0] andWideRes;
  wire logic [`ALU_DATA_W-1:0] andRangeRes;
  wire logic [`ALU_DATA_W-1:0] andStackRes;
  wire logic [`ALU_DATA_W-1:0] orWordRes;
  // 16-bit forms leave the upper half of the accumulator at zero
  assign andWordRes = {`ALU_HALF_ZERO, acc_q[`ALU_HALF_W-1:0] & memWord};
  assign andWideRes = acc_q & constWord;
  assign andRangeRes = acc_q & pattern;
  assign andStackRes = acc_q & stack_q[0];
  assign orWordRes = {`ALU_HALF_ZERO, acc_q[`ALU_HALF_W-1:0] | memWord};

  wire logic logicOp;
  wire logic negWrite;
  assign logicOp = isAndWord || isAndWide || rangeRun || isAndStack || isOrWord;
  // the or-word form reports zero only, negative keeps its old value
  assign negWrite = isAndWide || rangeRun || isAndStack;

  always_comb begin
    acc_d = acc_q;
    if (isLoad) begin
      acc_d = constWord;
    end else if (isAndWord) begin
      acc_d = andWordRes;
    end else if (isAndWide) begin
      acc_d = andWideRes;
    end else if (rangeRun) begin
      acc_d = andRangeRes;
    end else if (isAndStack) begin
      acc_d = andStackRes;
    end else if (isOrWord) begin
      acc_d = orWordRes;
    end
  end

  // flags are only rewritten by an instruction that owns them
  assign zero_d = logicOp ? (acc_d == `ALU_ACC_RESET) : zero_q;
  assign neg_d = negWrite ? acc_d[`ALU_MSB] : neg_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      acc_q <= `ALU_ACC_RESET;
      zero_q <= 1'b0;
      neg_q <= 1'b0;
      done_q <= 1'b0;
      badCount_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      neg_q <= neg_d;
      done_q <= cmdValid;
      badCount_q <= rangeBad;
    end
  end

  // load pushes the old accumulator, stack and pops; bottom refills with zero
  genvar e;
  generate
    for (e = 0; e < STACK_DEPTH; e++) begin : g_stack
      wire logic [`ALU_DATA_W-1:0] below;
      wire logic [`ALU_DATA_W-1:0] above;
      if (e == STACK_DEPTH - 1) begin : g_last
        assign below = `ALU_ACC_RESET;
      end else begin : g_mid
        assign below = stack_q[e+1];
      end
      if (e == 0) begin : g_first
        assign above = acc_q;
      end else begin : g_rest
        assign above = stack_q[e-1];
      end
      always_ff @(posedge mclk) begin
        if (reset) begin
          stack_q[e] <= `ALU_ACC_RESET;
        end else if (isLoad) begin
          stack_q[e] <= above;
        end else if (isAndStack) begin
          stack_q[e] <= below;
        end
      end
    end
  endgenerate

  assign acc = acc_q;
  assign stackTop = stack_q[0];
  assign zero_result_flag = zero_q;
  assign negative_result_flag = neg_q;
  assign done = done_q;
  assign badCount = badCount_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence sAndWord;
    isAndWord;
  endsequence
  sequence sWide;
    isAndWide;
  endsequence
  sequence sStack;
    isAndStack;
  endsequence
  sequence sOrWord;
    isOrWord;
  endsequence
  sequence sIdleTwo;
    !cmdValid [*2];
  endsequence

  AST_AND_WORD: assert property (sAndWord |=>
    acc_q == {`ALU_HALF_ZERO, $past(acc_q[`ALU_HALF_W-1:0]) & $past(memWord)})
    else $error("and word result wrong");
  AST_AND_WIDE: assert property (sWide |=> acc_q == ($past(acc_q) & $past(constWord)))
    else $error("and wide constant result wrong");
  AST_WIDE_FULL: assert property (sWide ##0 (constWord == 32'hFFFF_FFFF) |=>
    $stable(acc_q))
    else $error("all ones constant changed accumulator");
  AST_ZERO_FLAG: assert property (logicOp |=> zero_q == (acc_q == `ALU_ACC_RESET))
    else $error("zero flag mismatch");
  AST_NEG_FLAG: assert property (negWrite |=> neg_q == acc_q[`ALU_MSB])
    else $error("negative flag mismatch");
  AST_FLAGS_HOLD: assert property (sIdleTwo |-> $stable(zero_q) && $stable(neg_q))
    else $error("flags moved with no instruction");
  AST_RANGE: assert property (rangeRun |=> acc_q == ($past(acc_q) & $past(pattern)))
    else $error("bit range result wrong");
  AST_BAD_COUNT: assert property (rangeBad |=> badCount_q && $stable(acc_q) && $stable(zero_q))
    else $error("bad count not refused");
  AST_STACK_AND: assert property (sStack |=> acc_q == ($past(acc_q) & $past(stack_q[0])))
    else $error("stack and result wrong");
  AST_STACK_POP: assert property (sStack |=> stack_q[0] == $past(stack_q[1]))
    else $error("stack did not move up");
  AST_OR_WORD: assert property (sOrWord |=>
    acc_q == {`ALU_HALF_ZERO, $past(acc_q[`ALU_HALF_W-1:0]) | $past(memWord)})
    else $error("or word result wrong");
  AST_OR_NEG: assert property (sOrWord |=> $stable(neg_q) ##1 1'b1)
    else $error("or word touched negative flag");
  AST_DISABLED: assert property (cmdValid && !cmd.enable |=>
    $stable(acc_q) && $stable(zero_q) && $stable(neg_q) && $stable(stack_q[0]))
    else $error("disabled instruction changed state");
  AST_AND_WORD_NEG: assert property (sAndWord |=> $stable(neg_q))
    else $error("and word touched negative flag");
  AST_STACK_BOTTOM: assert property (sStack |=> stack_q[STACK_DEPTH-1] == `ALU_ACC_RESET)
    else $error("stack bottom not refilled with zero");
  AST_BAD_HOLD: assert property (rangeBad |=> $stable(neg_q) && $stable(stack_q[0]))
    else $error("bad count moved negative flag or stack");
endmodule
`default_nettype wire

// file: testbench/tb_accumulator_logic_and_or_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_accumulator_logic_and_or_unit;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cmdValid = 1'b0;
  alu_logic_pkg::cmd_t cmd = '0;
  logic [1023:0] bitMem = '0;
  logic [31:0] acc;
  logic [31:0] stackTop;
  logic zero_result_flag;
  logic negative_result_flag;
  logic done;
  logic badCount;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  integer seed = 32'h3be5_438f;
  logic [31:0] accM = '0;
  logic [31:0] stk [8];
  logic zM = 1'b0;
  logic nM = 1'b0;
  alu_logic_pkg::op_t ops [6] = '{alu_logic_pkg::OP_AND_WORD, alu_logic_pkg::OP_AND_WIDE_CONST,
    alu_logic_pkg::OP_AND_BIT_RANGE, alu_logic_pkg::OP_AND_STACK, alu_logic_pkg::OP_OR_WORD, alu_logic_pkg::OP_LOAD};

  always #4 mclk = ~mclk;

  accumulator_logic_and_or_unit dut_u (.mclk(mclk), .reset(reset), .cmdValid(cmdValid), .cmd(cmd),
    .bitMem(bitMem), .acc(acc), .stackTop(stackTop), .zero_result_flag(zero_result_flag),
    .negative_result_flag(negative_result_flag), .done(done), .badCount(badCount));

  // bits past the end of bit memory read as zero
  function automatic logic [31:0] gather(input logic [1023:0] m, input logic [9:0] s, input logic [5:0] c);
    logic [31:0] p;
    int j;
    p = '0;
    for (int i = 0; i < 32; i++) begin
      j = int'(s) + i;
      if (i < int'(c) && j < 1024) p[i] = m[j];
    end
    return p;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // with no instruction in flight every output must match the model and pulses stay low
  task automatic idle_check();
    chk(acc, accM);
    chk(stackTop, stk[0]);
    chk({30'h0000_0000, zero_result_flag, negative_result_flag}, {30'h0000_0000, zM, nM});
    chk({30'h0000_0000, done, badCount}, 32'h0000_0000);
  endtask

  task automatic run(input alu_logic_pkg::op_t op, input logic en, input logic [31:0] k, input logic [9:0] s,
                     input logic [5:0] c);
    logic [1023:0] bm;
    logic [31:0] r;
    logic bad;
    for (int i = 0; i < 32; i++) bm[i*32 +: 32] = $random(seed);
    @(posedge mclk);
    cmdValid <= 1'b1;
    bitMem <= bm;
    cmd.op <= op;
    cmd.enable <= en;
    cmd.memWord <= k[15:0];
    cmd.constWord <= k;
    cmd.bitStart <= s;
    cmd.bitCount <= c;
    bad = en && op == alu_logic_pkg::OP_AND_BIT_RANGE && (c == 6'h00 || c > 6'h20);
    if (en && !bad) begin
      case (op)
        alu_logic_pkg::OP_AND_WORD: begin r = {16'h0000, accM[15:0] & k[15:0]}; zM = r == 0; end
        alu_logic_pkg::OP_OR_WORD: begin r = {16'h0000, accM[15:0] | k[15:0]}; zM = r == 0; end
        alu_logic_pkg::OP_AND_WIDE_CONST: begin r = accM & k; zM = r == 0; nM = r[31]; end
        alu_logic_pkg::OP_AND_BIT_RANGE: begin r = accM & gather(bm, s, c); zM = r == 0; nM = r[31]; end
        alu_logic_pkg::OP_AND_STACK: begin
          r = accM & stk[0];
          zM = r == 0;
          nM = r[31];
          for (int i = 0; i < 7; i++) stk[i] = stk[i+1];
          stk[7] = '0;
        end
        default: begin
          for (int i = 7; i > 0; i--) stk[i] = stk[i-1];
          stk[0] = accM;
          r = k;
        end
      endcase
      accM = r;
    end
    @(posedge mclk);
    cmdValid <= 1'b0;
    #1;
    chk(acc, accM);
    chk(stackTop, stk[0]);
    chk({30'h0000_0000, zero_result_flag, negative_result_flag}, {30'h0000_0000, zM, nM});
    chk({30'h0000_0000, done, badCount}, {30'h0000_0000, 1'b1, bad});
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    foreach (stk[i]) stk[i] = '0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    #1;
    idle_check();
    // fill all eight levels, then pop past the bottom
    for (int i = 0; i < 8; i++) run(alu_logic_pkg::OP_LOAD, 1'b1, 32'hffff_fff0 | i, 10'h000, 6'h01);
    for (int i = 0; i < 9; i++) run(alu_logic_pkg::OP_AND_STACK, 1'b1, 32'h0000_0000, 10'h000, 6'h01);
    run(alu_logic_pkg::OP_LOAD, 1'b1, 32'hf000_00ff, 10'h000, 6'h01);
    run(alu_logic_pkg::OP_AND_WIDE_CONST, 1'b1, 32'hffff_ffff, 10'h000, 6'h01);
    run(alu_logic_pkg::OP_AND_WIDE_CONST, 1'b1, 32'h8765_4321, 10'h000, 6'h01);
    run(alu_logic_pkg::OP_OR_WORD, 1'b1, 32'h0000_0000, 10'h000, 6'h01);
    run(alu_logic_pkg::OP_LOAD, 1'b1, 32'hffff_ffff, 10'h000, 6'h01);
    // counts outside 1..32 must be refused untouched; then a count of 32 running past memory end, and a disabled range
    run(alu_logic_pkg::OP_AND_BIT_RANGE, 1'b1, 32'h0000_0000, 10'h010, 6'h00);
    run(alu_logic_pkg::OP_AND_BIT_RANGE, 1'b1, 32'h0000_0000, 10'h010, 6'h21);
    run(alu_logic_pkg::OP_AND_BIT_RANGE, 1'b1, 32'h0000_0000, 10'h3f0, 6'h20);
    run(alu_logic_pkg::OP_AND_BIT_RANGE, 1'b0, 32'h0000_0000, 10'h000, 6'h01);
    // idle gap: flags and accumulator hold with no instruction
    repeat (3) @(posedge mclk);
    #1;
    idle_check();
    // reset in mid-run clears accumulator, stack and flags
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    accM = '0;
    zM = 1'b0;
    nM = 1'b0;
    foreach (stk[i]) stk[i] = '0;
    #1;
    idle_check();
    for (int n = 0; n < 600; n++) begin
      run(ops[($random(seed) & 32'h7fff_ffff) % 6], ($random(seed) & 7) != 0,
          $random(seed), 10'($random(seed)), 6'(($random(seed) & 31) + 1));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
